// File: bench/msf_checker.sv
// Checker of fault latching, save pulses and bus timing at the block's ports.
`default_nettype none
module msf_checker #(
	parameter int START_WINDOW = 50
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Bus handshake.
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Pins.
	input wire logic heatsink_trip,
	input wire logic power_fail,
	input wire logic current_sync_pulse,
	// Motor, display and save outputs.
	input wire logic motor_enable,
	input wire logic fault_active,
	input wire logic [3:0] fault_tens,
	input wire logic [3:0] fault_ones,
	input wire logic thermal_save
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] run_cnt;
	logic seen;
	// Counts running cycles until the first current pulse of a start.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cnt <= '0;
			seen <= 1'b0;
		end else if (!motor_enable) begin
			run_cnt <= '0;
			seen <= 1'b0;
		end else begin
			seen <= seen | current_sync_pulse;
			run_cnt <= (seen | current_sync_pulse) ? '0 : run_cnt + 1;
		end
	end
	property p_stop; fault_active |-> !motor_enable; endproperty
	a_stop: assert property (p_stop) else $error("motor on with fault");
	property p_code; $rose(fault_active) |-> {fault_tens, fault_ones} inside
		{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h10, 8'h15, 8'h16}; endproperty
	a_code: assert property (p_code) else $error("bad fault digits");
	property p_held; fault_active && $past(fault_active) |-> $stable({fault_tens, fault_ones});
	endproperty
	a_held: assert property (p_held) else $error("held code changed");
	property p_heat; heatsink_trip [*4] |-> fault_active; endproperty
	a_heat: assert property (p_heat) else $error("trip not latched");
	property p_start; motor_enable |-> run_cnt <= START_WINDOW + 8; endproperty
	a_start: assert property (p_start) else $error("start without pulse");
	property p_answer; psel && penable && !pready |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("no bus answer");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
	property p_save; $rose(power_fail) |-> ##[1:8] thermal_save; endproperty
	a_save: assert property (p_save) else $error("image not saved");
	property p_save_pulse; thermal_save |=> !thermal_save; endproperty
	a_save_pulse: assert property (p_save_pulse) else $error("save too long");
	// Main scenarios reached.
	c_latch: cover property ($rose(fault_active));
	c_clear: cover property ($fell(fault_active));
	c_save: cover property (thermal_save);
endmodule
bind msf_fault_ctrl msf_checker #(.START_WINDOW(START_WINDOW)) i_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.heatsink_trip(heatsink_trip), .power_fail(power_fail),
	.current_sync_pulse(current_sync_pulse), .motor_enable(motor_enable),
	.fault_active(fault_active), .fault_tens(fault_tens), .fault_ones(fault_ones),
	.thermal_save(thermal_save));
`default_nettype wire

// File: bench/msf_panel.sv
// Model of the operator keypad and the control terminal contacts.
`default_nettype none
module msf_panel (
	// Clock.
	input wire logic pclk,
	// Keypad key and terminals two to six.
	output logic keypad_reset_key,
	output logic [4:0] terminal
);
	timeunit 1ns;
	timeprecision 1ns;
	// Key released and contacts open at power-up.
	initial begin
		keypad_reset_key = 1'b0;
		terminal = 5'h00;
	end
	// Holds the key long enough for the pin synchroniser to see it.
	task automatic press_key(input int hold);
		@(posedge pclk);
		keypad_reset_key <= 1'b1;
		repeat (hold) @(posedge pclk);
		keypad_reset_key <= 1'b0;
	endtask
	// Closes or opens one contact.
	task automatic set_terminal(input int idx, input logic level);
		@(posedge pclk);
		terminal[idx] <= level;
	endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the fault latching and reset block.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WIN = 50;
	localparam logic [15:0] RESTORE = 16'h0a5c;
	localparam logic [7:0] ADDRS [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h30};
	localparam logic [31:0] VALS [7] = '{msf_pkg::CTRL_RESET, msf_pkg::UNDERVOLT_RESET,
		msf_pkg::OVERVOLT_RESET, msf_pkg::UNBALANCE_RESET, msf_pkg::THERMAL_RESET, 32'h0, 32'h0};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, heatsink_trip, power_fail;
	logic motor_enable, fault_active, thermal_save, irq, keypad_reset_key, isync;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] terminal;
	logic [11:0] line_v;
	logic [3:0] fault_tens, fault_ones;
	logic [15:0] save_value;
	int n_mismatch, cmp_count, n;
	msf_fault_ctrl #(.START_WINDOW(WIN)) i_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.keypad_reset_key(keypad_reset_key), .digital_input_two(terminal[0]),
		.digital_input_three(terminal[1]), .digital_input_four(terminal[2]),
		.digital_input_five(terminal[3]), .digital_input_six(terminal[4]),
		.heatsink_trip(heatsink_trip), .voltage_sync_pulse(1'b0), .current_sync_pulse(isync),
		.power_fail(power_fail), .thermal_restore_value(RESTORE), .line_voltage_ab(line_v),
		.line_voltage_bc(line_v), .line_voltage_ca(line_v), .motor_current(12'h000),
		.motor_enable(motor_enable), .fault_active(fault_active), .fault_tens(fault_tens),
		.fault_ones(fault_ones), .thermal_save(thermal_save), .thermal_save_value(save_value),
		.irq(irq));
	msf_panel i_panel (.pclk(pclk), .keypad_reset_key(keypad_reset_key), .terminal(terminal));
	// Free-running clock.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Compares a value seen with the value expected.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One bus transfer; read data and error are taken at the answering edge.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= addr;
		pwrite <= wr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Waits a bounded time for the fault flag to reach a level.
	task automatic wait_fault(input logic lvl, input int lim);
		n = 0;
		while (fault_active !== lvl && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask
	// Checks the shown digits and that the motor is stopped.
	task automatic expect_code(input logic [7:0] code);
		check("fault digits", 32'({fault_tens, fault_ones}), 32'(code));
		check("motor enable", 32'(motor_enable), 32'h0);
	endtask
	// Trips the thermostat briefly so that a fault is latched.
	task automatic latch_heat();
		@(posedge pclk);
		heatsink_trip <= 1'b1;
		wait_fault(1'b1, 10);
		heatsink_trip <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask
	// Pulses one terminal contact.
	task automatic pulse(input int idx);
		i_panel.set_terminal(idx, 1'b1);
		repeat (4) @(posedge pclk);
		i_panel.set_terminal(idx, 1'b0);
		repeat (6) @(posedge pclk);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		repeat (90000) @(posedge pclk);
		n_mismatch++;
		stop_test();
	end
	// Test sequence.
	initial begin
		{presetn, psel, penable, pwrite, heatsink_trip, power_fail, isync} = 7'h00;
		{paddr, pwdata, line_v} = '0;
		line_v = 12'h064;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, ADDRS[i], 32'h0);
			check("reset value", rd, VALS[i]);
			check("slave error", 32'(err), 32'(i == 6));
		end
		apb(1'b0, msf_pkg::IMAGE_OFFSET, 32'h0);
		check("image", rd, {8'h00, RESTORE, 8'h00});
		power_fail <= 1'b1;
		n = 0;
		while (thermal_save !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		check("saved image", 32'(save_value), 32'(RESTORE));
		power_fail <= 1'b0;
		$display("registers and image done");
		apb(1'b1, msf_pkg::IRQ_ENABLE_OFFSET, 32'h1);
		latch_heat();
		expect_code(8'h04);
		check("irq", 32'(irq), 32'h1);
		apb(1'b0, msf_pkg::STATUS_OFFSET, 32'h0);
		check("status", 32'(rd[8:0]), 32'h104);
		i_panel.press_key(2);
		wait_fault(1'b0, 20);
		check("keypad clear", 32'(fault_active), 32'h0);
		apb(1'b1, msf_pkg::IRQ_CLEAR_OFFSET, 32'h3);
		apb(1'b1, msf_pkg::IRQ_ENABLE_OFFSET, 32'h0);
		check("irq cleared", 32'(irq), 32'h0);
		$display("heat sink and keypad done");
		for (int i = 0; i < 5; i++) begin
			latch_heat();
			pulse(i);
			expect_code(8'h04);
			apb(1'b1, 8'h00, 32'(i < 2 ? msf_pkg::RESET_FUNC_LOW : msf_pkg::RESET_FUNC_HIGH)
				<< (4 + 4 * i));
			pulse(i);
			check("input clear", 32'(fault_active), 32'h0);
		end
		check("irq masked", 32'(irq), 32'h0);
		$display("input resets done");
		apb(1'b1, 8'h00, 32'h1);
		heatsink_trip <= 1'b1;
		wait_fault(1'b1, 10);
		expect_code(8'h04);
		heatsink_trip <= 1'b0;
		wait_fault(1'b0, 20);
		check("auto clear", 32'(fault_active), 32'h0);
		apb(1'b1, 8'h00, 32'h2);
		isync <= 1'b1;
		wait_fault(1'b1, WIN + 20);
		expect_code(8'h02);
		i_panel.press_key(2);
		wait_fault(1'b0, 20);
		apb(1'b1, 8'h00, 32'h3);
		wait_fault(1'b1, WIN + 20);
		expect_code(8'h15);
		repeat (100) @(posedge pclk);
		expect_code(8'h15);
		apb(1'b0, 8'h00, 32'h0);
		check("run bit", 32'(rd[1]), 32'h0);
		i_panel.press_key(3);
		wait_fault(1'b0, 20);
		apb(1'b1, msf_pkg::COPY_OFFSET, 32'h31);
		wait_fault(1'b1, 10);
		expect_code(8'h10);
		apb(1'b1, msf_pkg::COPY_OFFSET, 32'(msf_pkg::OWN_VERSION));
		wait_fault(1'b0, 20);
		check("copy clear", 32'(fault_active), 32'h0);
		$display("auto reset, start and copy done");
		i_panel.set_terminal(2, 1'b1);
		apb(1'b1, 8'h00, 32'(msf_pkg::EXT_FAULT_FUNC) << msf_pkg::FUNC_FOUR_LSB);
		i_panel.set_terminal(2, 1'b0);
		wait_fault(1'b1, 10);
		expect_code(8'h06);
		i_panel.set_terminal(2, 1'b1);
		i_panel.press_key(2);
		wait_fault(1'b0, 20);
		check("external clear", 32'(fault_active), 32'h0);
		apb(1'b1, msf_pkg::OVERVOLT_OFFSET, 32'h0001_0078);
		wait_fault(1'b1, 45000);
		expect_code(8'h16);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		check("power-on clear", 32'(fault_active), 32'h0);
		$display("external, overvoltage and power-on done");
		stop_test();
	end
endmodule
`default_nettype wire

// File: core/msf_fault_ctrl.sv
// Fault detection, latching and reset control of the motor soft starter.
`default_nettype none
//Behaviour
//- Fault stops motor, shows E plus number.
//- Fault stays latched until valid reset.
//- Power cycle reset clears latched fault.
//- Keypad reset key clears latched fault.
//- Auto-reset setting clears eligible faults itself.
//- Input resets only with reset function code.
//- Phase deviation versus other two flags unbalance.
//- No voltage sync at start flags phase.
//- Heat-sink thermostat raises E04.
//- Overload beyond thermal class raises E05.
//- Open no-external-fault input raises E06.
//- Copy version mismatch raises E10.
//- No current sync at start raises E15.
//- High line voltage for time raises E16.
module msf_fault_ctrl #(
	parameter int START_WINDOW = msf_pkg::START_WINDOW_CYCLES
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins from the operator keypad, control terminals, heat-sink thermostat, sync detectors, power monitor and image store.
	input wire logic keypad_reset_key,
	input wire logic digital_input_two,
	input wire logic digital_input_three,
	input wire logic digital_input_four,
	input wire logic digital_input_five,
	input wire logic digital_input_six,
	input wire logic heatsink_trip,
	input wire logic voltage_sync_pulse,
	input wire logic current_sync_pulse,
	input wire logic power_fail,
	input wire logic [15:0] thermal_restore_value,
	// Measurements from on-chip converters.
	input wire logic [11:0] line_voltage_ab,
	input wire logic [11:0] line_voltage_bc,
	input wire logic [11:0] line_voltage_ca,
	input wire logic [11:0] motor_current,
	// Motor, display, save and interrupt outputs.
	output logic motor_enable,
	output logic fault_active,
	output logic [3:0] fault_tens,
	output logic [3:0] fault_ones,
	output logic thermal_save,
	output logic [15:0] thermal_save_value,
	output logic irq
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] uv;
		logic [31:0] ov;
		logic [31:0] unb;
		logic [31:0] therm;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic [7:0] code;
		logic [9:0] pins_q;
		logic [15:0] ms_cnt;
		logic ms_tick;
		logic [31:0] start_cnt;
		logic vsync_seen;
		logic isync_seen;
		logic phase_start;
		logic nocur_start;
		logic [23:0] image;
		logic [1:0] restore_cnt;
		logic copy_bad;
		logic save;
		logic [15:0] save_val;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic motor_en;
		logic fault;
		logic [3:0] tens;
		logic [3:0] ones;
		logic irq;
	} msf_state_type;
	msf_state_type state;
	msf_state_type next_state;

	logic [9:0] pins;
	logic [15:0] restore_sync;
	logic uv_hold;
	logic ov_hold;
	logic unb_hold;
	logic uv_cond;
	logic ov_cond;
	logic unb_cond;

	// True when v is below pct percent of ref.
	function automatic logic below_pct(input logic [11:0] v, input logic [11:0] ref_v,
		input logic [7:0] pct);
		return (20'(v) * 20'd100) < (20'(ref_v) * 20'(pct));
	endfunction

	// True when v deviates from the mean of the other two by more than pct percent.
	function automatic logic deviates(input logic [11:0] v, input logic [11:0] o1,
		input logic [11:0] o2, input logic [7:0] pct);
		logic [13:0] sum;
		logic [13:0] twice;
		logic [13:0] diff;
		sum = 14'(o1) + 14'(o2);
		twice = {1'b0, v, 1'b0};
		diff = (twice > sum) ? twice - sum : sum - twice;
		return (22'(diff) * 22'd100) > (22'(pct) * 22'(sum));
	endfunction

	// Extracts one four-bit input function selection from the control word.
	function automatic logic [3:0] func_of(input logic [31:0] ctrl, input int lsb);
		return 4'(ctrl >> lsb);
	endfunction

	// Pin synchronisers.
	msf_sync #(.W(10)) pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({power_fail, current_sync_pulse, voltage_sync_pulse, heatsink_trip,
			digital_input_six, digital_input_five, digital_input_four,
			digital_input_three, digital_input_two, keypad_reset_key}),
		.q(pins)
	);
	msf_sync #(.W(16)) restore_sync_i (
		.pclk(pclk),
		.presetn(presetn),
		.d(thermal_restore_value),
		.q(restore_sync)
	);

	// Line voltage conditions for the persistence timers.
	always_comb begin
		uv_cond = state.motor_en && (
			below_pct(line_voltage_ab, state.uv[11:0], state.uv[23:16]) ||
			below_pct(line_voltage_bc, state.uv[11:0], state.uv[23:16]) ||
			below_pct(line_voltage_ca, state.uv[11:0], state.uv[23:16]));
		ov_cond = !below_pct(line_voltage_ab, state.ov[11:0], state.ov[23:16] + 8'h01) ||
			!below_pct(line_voltage_bc, state.ov[11:0], state.ov[23:16] + 8'h01) ||
			!below_pct(line_voltage_ca, state.ov[11:0], state.ov[23:16] + 8'h01);
		unb_cond = state.motor_en && (
			deviates(line_voltage_ab, line_voltage_bc, line_voltage_ca, state.unb[7:0]) ||
			deviates(line_voltage_bc, line_voltage_ab, line_voltage_ca, state.unb[7:0]) ||
			deviates(line_voltage_ca, line_voltage_ab, line_voltage_bc, state.unb[7:0]));
	end

	// Persistence timers, limits in milliseconds.
	msf_hold_timer uv_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cond(uv_cond),
		.ms_tick(state.ms_tick),
		.limit(state.uv[31:16] ^ state.uv[31:16] | state.ov[31:16]),
		.expired(uv_hold)
	);
	msf_hold_timer ov_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cond(ov_cond),
		.ms_tick(state.ms_tick),
		.limit(state.ov[31:16]),
		.expired(ov_hold)
	);
	msf_hold_timer unb_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cond(unb_cond),
		.ms_tick(state.ms_tick),
		.limit(state.unb[31:16]),
		.expired(unb_hold)
	);

	// Detection, latching, reset sources, thermal image and register access.
	always_comb begin
		logic [9:0] rise;
		logic access;
		logic di_reset;
		logic ext_open;
		logic clear;
		logic auto_ok;
		logic [7:0] new_code;
		logic [1:0] events;
		logic [1:0] irq_clr;
		rise = '0;
		access = 1'b0;
		di_reset = 1'b0;
		ext_open = 1'b0;
		clear = 1'b0;
		auto_ok = 1'b0;
		new_code = msf_pkg::CODE_NONE;
		events = 2'b00;
		irq_clr = 2'b00;
		next_state = state;
		rise = pins & ~state.pins_q;
		next_state.pins_q = pins;
		// Millisecond time base.
		next_state.ms_tick = (state.ms_cnt == 16'(msf_pkg::CYCLES_PER_MS - 1));
		next_state.ms_cnt = next_state.ms_tick ? 16'h0000 : state.ms_cnt + 16'h0001;
		// Input reset and external fault decoding.
		di_reset = (rise[1] && func_of(state.ctrl, msf_pkg::FUNC_TWO_LSB) ==
				msf_pkg::RESET_FUNC_LOW) ||
			(rise[2] && func_of(state.ctrl, msf_pkg::FUNC_THREE_LSB) ==
				msf_pkg::RESET_FUNC_LOW) ||
			(rise[3] && func_of(state.ctrl, msf_pkg::FUNC_FOUR_LSB) ==
				msf_pkg::RESET_FUNC_HIGH) ||
			(rise[4] && func_of(state.ctrl, msf_pkg::FUNC_FIVE_LSB) ==
				msf_pkg::RESET_FUNC_HIGH) ||
			(rise[5] && func_of(state.ctrl, msf_pkg::FUNC_SIX_LSB) ==
				msf_pkg::RESET_FUNC_HIGH);
		ext_open = (!pins[3] && func_of(state.ctrl, msf_pkg::FUNC_FOUR_LSB) ==
				msf_pkg::EXT_FAULT_FUNC) ||
			(!pins[4] && func_of(state.ctrl, msf_pkg::FUNC_FIVE_LSB) ==
				msf_pkg::EXT_FAULT_FUNC) ||
			(!pins[5] && func_of(state.ctrl, msf_pkg::FUNC_SIX_LSB) ==
				msf_pkg::EXT_FAULT_FUNC);
		// Start window watches for both synchronism pulses.
		next_state.phase_start = 1'b0;
		next_state.nocur_start = 1'b0;
		if (state.start_cnt != 32'h0000_0000) begin
			next_state.start_cnt = state.start_cnt - 32'h0000_0001;
			next_state.vsync_seen = state.vsync_seen | rise[7];
			next_state.isync_seen = state.isync_seen | rise[8];
			if (state.start_cnt == 32'h0000_0001) begin
				next_state.phase_start = !(state.vsync_seen | rise[7]);
				next_state.nocur_start = !(state.isync_seen | rise[8]);
			end
		end
		// Thermal image rises with excess current and cools by one count per millisecond.
		if (state.ms_tick) begin
			if (motor_current > state.therm[27:16]) begin
				next_state.image = state.image + 24'(motor_current - state.therm[27:16]);
			end else if (state.image != 24'h00_0000) begin
				next_state.image = state.image - 24'h00_0001;
			end
		end
		if (state.restore_cnt != 2'b11) begin
			next_state.restore_cnt = state.restore_cnt + 2'b01;
			if (state.restore_cnt == 2'b10) begin
				next_state.image = {restore_sync, 8'h00};
			end
		end
		next_state.save = rise[9];
		if (rise[9]) begin
			next_state.save_val = state.image[23:8];
		end
		// Priority among causes that appear together.
		if (state.nocur_start) begin
			new_code = msf_pkg::CODE_NO_CURRENT;
		end else if (state.phase_start || unb_hold) begin
			new_code = msf_pkg::CODE_PHASE;
		end else if (uv_hold) begin
			new_code = msf_pkg::CODE_UNDERVOLT;
		end else if (ov_hold) begin
			new_code = msf_pkg::CODE_OVERVOLT;
		end else if (pins[6]) begin
			new_code = msf_pkg::CODE_HEATSINK;
		end else if (state.image[23:8] >= state.therm[15:0]) begin
			new_code = msf_pkg::CODE_OVERLOAD;
		end else if (ext_open) begin
			new_code = msf_pkg::CODE_EXTERNAL;
		end else if (state.copy_bad) begin
			new_code = msf_pkg::CODE_COPY;
		end
		// Automatic reset once the cause has gone, never for a missing motor.
		case (state.code)
			msf_pkg::CODE_PHASE: auto_ok = !unb_cond;
			msf_pkg::CODE_UNDERVOLT: auto_ok = !uv_cond;
			msf_pkg::CODE_OVERVOLT: auto_ok = !ov_cond;
			msf_pkg::CODE_HEATSINK: auto_ok = !pins[6];
			msf_pkg::CODE_OVERLOAD: auto_ok = state.image[23:8] < state.therm[15:0];
			msf_pkg::CODE_EXTERNAL: auto_ok = !ext_open;
			msf_pkg::CODE_COPY: auto_ok = !state.copy_bad;
			default: auto_ok = 1'b0;
		endcase
		clear = rise[0] || di_reset ||
			(state.ctrl[msf_pkg::AUTO_RESET_BIT] && auto_ok);
		// Latch: first cause wins while no fault is held, a cause beats a clear.
		if (state.code == msf_pkg::CODE_NONE || clear) begin
			next_state.code = new_code;
			if (clear && state.code != msf_pkg::CODE_NONE) begin
				events[1] = 1'b1;
				if (rise[0] || di_reset) begin
					next_state.copy_bad = 1'b0;
				end
			end
			if (new_code != msf_pkg::CODE_NONE) begin
				events[0] = 1'b1;
			end
		end
		// APB access: answer one cycle after the first access cycle.
		access = psel && penable && !state.pready;
		next_state.pready = access;
		next_state.pslverr = 1'b0;
		if (access) begin
			next_state.prdata = 32'h0000_0000;
			if (pwrite) begin
				case (paddr)
					msf_pkg::CTRL_OFFSET: next_state.ctrl = pwdata;
					msf_pkg::UNDERVOLT_OFFSET: next_state.uv = pwdata;
					msf_pkg::OVERVOLT_OFFSET: next_state.ov = pwdata;
					msf_pkg::UNBALANCE_OFFSET: next_state.unb = pwdata;
					msf_pkg::THERMAL_OFFSET: next_state.therm = pwdata;
					msf_pkg::COPY_OFFSET: next_state.copy_bad =
						(pwdata[7:0] != msf_pkg::OWN_VERSION);
					msf_pkg::IRQ_CLEAR_OFFSET: irq_clr = pwdata[1:0];
					msf_pkg::IRQ_ENABLE_OFFSET: next_state.irq_enable = pwdata[1:0];
					default: next_state.pslverr = 1'b1;
				endcase
			end else begin
				case (paddr)
					msf_pkg::CTRL_OFFSET: next_state.prdata = state.ctrl;
					msf_pkg::UNDERVOLT_OFFSET: next_state.prdata = state.uv;
					msf_pkg::OVERVOLT_OFFSET: next_state.prdata = state.ov;
					msf_pkg::UNBALANCE_OFFSET: next_state.prdata = state.unb;
					msf_pkg::THERMAL_OFFSET: next_state.prdata = state.therm;
					msf_pkg::STATUS_OFFSET: next_state.prdata =
						{22'h00_0000, state.motor_en, state.code != msf_pkg::CODE_NONE,
						state.code};
					msf_pkg::IRQ_STATUS_OFFSET: next_state.prdata = {30'h0, state.irq_status};
					msf_pkg::IRQ_ENABLE_OFFSET: next_state.prdata = {30'h0, state.irq_enable};
					msf_pkg::IMAGE_OFFSET: next_state.prdata = {8'h00, state.image};
					msf_pkg::COPY_OFFSET: next_state.prdata = 32'h0000_0000;
					msf_pkg::IRQ_CLEAR_OFFSET: next_state.prdata = 32'h0000_0000;
					default: next_state.pslverr = 1'b1;
				endcase
			end
		end
		// A new fault drops the run request; a fresh run request opens the start window.
		if (next_state.code != msf_pkg::CODE_NONE) begin
			next_state.ctrl[msf_pkg::RUN_BIT] = 1'b0;
		end
		next_state.motor_en = next_state.ctrl[msf_pkg::RUN_BIT] &&
			next_state.code == msf_pkg::CODE_NONE;
		if (next_state.motor_en && !state.motor_en) begin
			next_state.start_cnt = 32'(START_WINDOW);
			next_state.vsync_seen = 1'b0;
			next_state.isync_seen = 1'b0;
		end else if (!next_state.motor_en) begin
			next_state.start_cnt = 32'h0000_0000;
		end
		// Fault flag and display digits after the letter E.
		next_state.fault = next_state.code != msf_pkg::CODE_NONE;
		next_state.tens = 4'(next_state.code / 8'd10);
		next_state.ones = 4'(next_state.code % 8'd10);
		// Sticky interrupt status; a new event wins over a clear.
		next_state.irq_status = (state.irq_status & ~irq_clr) | events;
		next_state.irq = |(next_state.irq_status & next_state.irq_enable);
	end

	// State register; power-on reset clears any latched fault.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
			state.ctrl <= msf_pkg::CTRL_RESET;
			state.uv <= msf_pkg::UNDERVOLT_RESET;
			state.ov <= msf_pkg::OVERVOLT_RESET;
			state.unb <= msf_pkg::UNBALANCE_RESET;
			state.therm <= msf_pkg::THERMAL_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from the state register.
	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign motor_enable = state.motor_en;
	assign fault_active = state.fault;
	assign fault_tens = state.tens;
	assign fault_ones = state.ones;
	assign thermal_save = state.save;
	assign thermal_save_value = state.save_val;
	assign irq = state.irq;
endmodule
`default_nettype wire

// File: core/msf_hold_timer.sv
// Persistence timer that reports a condition held for a programmed number of milliseconds.
`default_nettype none
module msf_hold_timer (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Condition, time base and limit in milliseconds.
	input wire logic cond,
	input wire logic ms_tick,
	input wire logic [15:0] limit,
	// Condition has lasted the limit.
	output logic expired
);
	typedef struct packed {
		logic [15:0] cnt;
		logic expired;
	} msf_timer_state_type;
	msf_timer_state_type state;
	msf_timer_state_type next_state;

	// Count whole milliseconds while the condition holds; any gap restarts the count.
	always_comb begin
		next_state = state;
		if (!cond) begin
			next_state.cnt = 16'h0000;
		end else if (ms_tick && state.cnt != limit) begin
			next_state.cnt = state.cnt + 16'h0001;
		end
		next_state.expired = cond && (state.cnt >= limit);
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign expired = state.expired;
endmodule
`default_nettype wire

// File: core/msf_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
`default_nettype none
module msf_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Pin side and synchronised side.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} msf_sync_state_type;
	msf_sync_state_type state;
	msf_sync_state_type next_state;

	// The first stage feeds only the second.
	always_comb begin
		next_state.meta = d;
		next_state.q = state.meta;
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign q = state.q;
endmodule
`default_nettype wire

// File: pkg/msf_pkg.sv
// Constants shared by the motor starter fault and reset block.
`default_nettype none
package msf_pkg;
	// Clock rate and derived time bases.
	localparam int CLK_HZ = 20_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
	localparam int START_WINDOW_MS = 10;
	localparam int START_WINDOW_CYCLES = START_WINDOW_MS * CYCLES_PER_MS;
	// Register byte offsets.
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] UNDERVOLT_OFFSET = 8'h04;
	localparam logic [7:0] OVERVOLT_OFFSET = 8'h08;
	localparam logic [7:0] UNBALANCE_OFFSET = 8'h0c;
	localparam logic [7:0] THERMAL_OFFSET = 8'h10;
	localparam logic [7:0] COPY_OFFSET = 8'h14;
	localparam logic [7:0] STATUS_OFFSET = 8'h18;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h1c;
	localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h20;
	localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h24;
	localparam logic [7:0] IMAGE_OFFSET = 8'h28;
	// Control register field positions.
	localparam int AUTO_RESET_BIT = 0;
	localparam int RUN_BIT = 1;
	localparam int FUNC_TWO_LSB = 4;
	localparam int FUNC_THREE_LSB = 8;
	localparam int FUNC_FOUR_LSB = 12;
	localparam int FUNC_FIVE_LSB = 16;
	localparam int FUNC_SIX_LSB = 20;
	// Input function selection codes.
	localparam logic [3:0] RESET_FUNC_LOW = 4'h2;
	localparam logic [3:0] RESET_FUNC_HIGH = 4'h6;
	localparam logic [3:0] EXT_FAULT_FUNC = 4'h5;
	// Fault numbers shown after the letter E.
	localparam logic [7:0] CODE_NONE = 8'h00;
	localparam logic [7:0] CODE_PHASE = 8'h02;
	localparam logic [7:0] CODE_UNDERVOLT = 8'h03;
	localparam logic [7:0] CODE_HEATSINK = 8'h04;
	localparam logic [7:0] CODE_OVERLOAD = 8'h05;
	localparam logic [7:0] CODE_EXTERNAL = 8'h06;
	localparam logic [7:0] CODE_COPY = 8'h0a;
	localparam logic [7:0] CODE_NO_CURRENT = 8'h0f;
	localparam logic [7:0] CODE_OVERVOLT = 8'h10;
	// Values after reset.
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] UNDERVOLT_RESET = 32'h0064_0050;
	localparam logic [31:0] OVERVOLT_RESET = 32'h0064_0078;
	localparam logic [31:0] UNBALANCE_RESET = 32'h0064_000f;
	localparam logic [31:0] THERMAL_RESET = 32'h0064_1000;
	localparam logic [7:0] OWN_VERSION = 8'h13;
endpackage
`default_nettype wire
